/* File: emb_ext_bus.sv */
// Purpose: external memory bus strobes, port 0/2 multiplexing and third port functions
// Assumes: core presents requests at the last clock of each machine cycle
// Notes: a data access takes one whole machine cycle, address in the first half
////////////////////////////////////////////////////////////////////////////////
module emb_ext_bus (
    input wire logic clk_in,                      // oscillator clock, 50 MHz
    input wire logic sys_rst_in,                  // synchronous reset, active high
    input wire logic reset_pin_in,                // device reset pin
    input wire logic double_speed_mode_in,        // machine cycle of 6 clocks
    input wire logic external_fetch_select_in,    // high allows internal fetch
    input wire logic ale_off_in,                  // software stops address strobe while select is high
    input wire logic [15:0] pc_in,                // program counter of next cycle
    input wire logic movx_req_in,                 // next cycle is a data access
    input wire logic movx_wr_in,                  // data access is a write
    input wire logic movx_wide_in,                // 16-bit data address
    input wire logic [15:0] movx_addr_in,         // data address
    input wire logic [7:0] movx_wdata_in,         // write data
    input wire logic [7:0] p0_latch_in,           // port 0 latch
    input wire logic [7:0] p2_latch_in,           // port 2 latch
    input wire logic [7:0] p3_latch_in,           // port 3 latch
    input wire logic [1:0] p4_latch_in,           // port 4 latch
    input wire logic serial_tx_en_in,             // serial owns transmit pin
    input wire logic serial_tx_in,                // transmit data or shift clock
    input wire logic serial_sync_in,              // synchronous serial mode
    input wire logic serial_rx_drive_in,          // sync mode shifts data out
    input wire logic serial_rx_val_in,            // sync data bit out
    input wire logic [7:0] port0_in,              // port 0 pin levels
    output logic [7:0] port0_out,                 // port 0 drive value
    output logic [7:0] port0_oe_out,              // port 0 drive enable
    output logic [7:0] port2_out,                 // port 2 drive value
    output logic [7:0] port2_oe_out,              // port 2 drive enable
    input wire logic [7:0] third_port_pins_in,    // port 3 pin levels
    output logic [7:0] third_port_pins_out,       // port 3 drive value
    output logic [7:0] third_port_pins_oe_out,    // port 3 drive enable
    output logic [1:0] fourth_port_pins_out,      // port 4 drive value
    output logic [1:0] fourth_port_pins_oe_out,   // port 4 drive enable
    output logic ale_out,                         // address latch strobe
    output logic program_fetch_strobe_n_out,      // program fetch strobe, low active
    output logic core_rst_out,                    // filtered device reset
    output logic mc_end_out,                      // requests sampled this clock
    output logic [7:0] fetch_byte_out,            // fetched code byte
    output logic fetch_valid_out,                 // fetch byte pulse
    output logic [7:0] read_data_out,             // external data read byte
    output logic read_valid_out,                  // read byte pulse
    output logic [7:0] third_port_read_out,       // port 3 pin levels, registered
    output logic serial_rx_data_out,              // gated receive input
    output logic external_irq_zero_n_out,         // gated interrupt 0 input
    output logic external_irq_one_n_out,          // gated interrupt 1 input
    output logic timer_zero_count_input_out,      // gated timer 0 count
    output logic timer_one_count_input_out        // gated timer 1 count
);
    import emb_pkg::*;

    typedef struct packed {
        emb_cyc_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wide;
        logic [7:0] fbyte;
        logic [7:0] rdata;
        logic fvalid;
        logic rvalid;
        logic [7:0] p3_rd;
        logic [5:0] gated;
    } emb_bus_st_t;

    emb_tim_if tim ();
    emb_bus_st_t r;
    emb_bus_st_t n;
    logic ext_fetch;
    logic addr_ph;
    logic data_half;
    logic rd_act;
    logic wr_act;
    logic cap;
    logic [15:0] cur_addr;
    logic [7:0] alt_act;
    logic [7:0] alt_val;

    emb_timing u_timing (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .reset_pin_in(reset_pin_in),
        .tim(tim)
    );

    assign tim.x2 = double_speed_mode_in;

    ////////////////////////////////////////////////////////////////////////////
    // cycle decode, fetch, read and write strobes from flip-flops only, ale_out also gated by ale_off_in and the select
    assign ext_fetch = !external_fetch_select_in || (pc_in >= EMB_INT_LIMIT);
    assign addr_ph = tim.sub < EMB_ADDR_SUBS;
    assign data_half = (r.kind == EMB_CYC_RD || r.kind == EMB_CYC_WR) && tim.half;
    assign cap = tim.sub >= tim.hl - 3'h1;
    // second fetch of a cycle takes the next code byte, a data access keeps its address
    assign cur_addr = r.addr + {15'h0000, tim.half && r.kind == EMB_CYC_FETCH};

    // one pulse per half unless in the second half of a data access or stopped by software, halves follow the mode length
    assign ale_out = !tim.core_rst && (tim.sub == 3'h0)
        && !data_half
        && !(ale_off_in && external_fetch_select_in);
    // active in the strobe part of both halves of an external fetch only
    assign program_fetch_strobe_n_out = !(r.kind == EMB_CYC_FETCH && !addr_ph);
    assign rd_act = (r.kind == EMB_CYC_RD) && tim.half && !addr_ph;
    assign wr_act = (r.kind == EMB_CYC_WR) && tim.half && !addr_ph;

    ////////////////////////////////////////////////////////////////////////////
    // port 0: address, then data or float, open drain when idle
    always_comb begin
        if (r.kind == EMB_CYC_INT) begin
            port0_out = 8'h00;
            port0_oe_out = ~p0_latch_in;
        end else if (addr_ph && !data_half) begin
            // held through sub-phase 1, past the strobe fall
            port0_out = cur_addr[7:0];
            port0_oe_out = 8'hFF;
        end else if (r.kind == EMB_CYC_WR && tim.half) begin
            port0_out = r.wdata;
            port0_oe_out = 8'hFF;
        end else begin
            port0_out = 8'h00;                            // memory owns the bus
            port0_oe_out = 8'h00;
        end
    end

    // port 2: high address when wide, else the latch as a quasi port
    always_comb begin
        if (r.kind != EMB_CYC_INT && r.wide) begin
            port2_out = cur_addr[15:8];
            port2_oe_out = 8'hFF;
        end else begin
            port2_out = p2_latch_in;
            port2_oe_out = ~p2_latch_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // third port secondary outputs, bit order fixed
    always_comb begin
        alt_act = 8'h00;
        alt_val = 8'hFF;
        alt_act[EMB_P3_RXD] = serial_sync_in && serial_rx_drive_in;
        alt_val[EMB_P3_RXD] = serial_rx_val_in;
        alt_act[EMB_P3_TXD] = serial_tx_en_in;
        alt_val[EMB_P3_TXD] = serial_tx_in;
        alt_act[EMB_P3_WR] = r.kind == EMB_CYC_WR;
        alt_val[EMB_P3_WR] = !wr_act;
        alt_act[EMB_P3_RD] = r.kind == EMB_CYC_RD;
        alt_val[EMB_P3_RD] = !rd_act;
    end

    // only zero is driven on quasi pins, one is left to the pull-up
    for (genvar i = 0; i < 8; i++) begin : g_p3
        always_comb begin
            if (EMB_P3_EXEMPT[i]) begin
                third_port_pins_out[i] = alt_act[i] ? alt_val[i] : p3_latch_in[i];
            end else begin
                third_port_pins_out[i] = p3_latch_in[i] && (!alt_act[i] || alt_val[i]);
            end
            third_port_pins_oe_out[i] = !third_port_pins_out[i]
                || (alt_act[i] && EMB_P3_STRONG[i]);
        end
    end

    assign fourth_port_pins_out = p4_latch_in;
    assign fourth_port_pins_oe_out = ~p4_latch_in;

    ////////////////////////////////////////////////////////////////////////////
    // cycle choice, byte capture and gated input functions
    always_comb begin
        n = r;
        n.fvalid = 1'b0;
        n.rvalid = 1'b0;
        if (tim.mc_end) begin
            if (movx_req_in) begin
                n.kind = movx_wr_in ? EMB_CYC_WR : EMB_CYC_RD;
                n.addr = movx_addr_in;
                n.wide = movx_wide_in;
            end else begin
                n.kind = ext_fetch ? EMB_CYC_FETCH : EMB_CYC_INT;
                n.addr = pc_in;
                n.wide = 1'b1;
            end
            n.wdata = movx_wdata_in;
        end
        // sample while the strobe is still active, memory drives then
        if (cap && r.kind == EMB_CYC_FETCH) begin
            n.fbyte = port0_in;
            n.fvalid = 1'b1;
        end
        if (cap && rd_act) begin
            n.rdata = port0_in;
            n.rvalid = 1'b1;
        end
        n.p3_rd = third_port_pins_in;
        // inputs with latch zero read as idle
        n.gated[0] = !p3_latch_in[EMB_P3_RXD] || third_port_pins_in[EMB_P3_RXD];
        n.gated[1] = !p3_latch_in[EMB_P3_IRQ0] || third_port_pins_in[EMB_P3_IRQ0];
        n.gated[2] = !p3_latch_in[EMB_P3_IRQ1] || third_port_pins_in[EMB_P3_IRQ1];
        n.gated[3] = p3_latch_in[EMB_P3_T0] && third_port_pins_in[EMB_P3_T0];
        n.gated[4] = p3_latch_in[EMB_P3_T1] && third_port_pins_in[EMB_P3_T1];
        n.gated[5] = 1'b0;
    end

    // the filtered reset clears the bus state like the system reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || tim.core_rst) begin
            r <= '{kind: EMB_CYC_INT, addr: 16'h0000, wdata: 8'h00, wide: 1'b0,
                fbyte: 8'h00, rdata: 8'h00, fvalid: 1'b0, rvalid: 1'b0,
                p3_rd: 8'hFF, gated: 6'h07};
        end else begin
            r <= n;
        end
    end

    assign core_rst_out = tim.core_rst;
    assign mc_end_out = tim.mc_end;
    assign fetch_byte_out = r.fbyte;
    assign fetch_valid_out = r.fvalid;
    assign read_data_out = r.rdata;
    assign read_valid_out = r.rvalid;
    assign third_port_read_out = r.p3_rd;
    assign serial_rx_data_out = r.gated[0];
    assign external_irq_zero_n_out = r.gated[1];
    assign external_irq_one_n_out = r.gated[2];
    assign timer_zero_count_input_out = r.gated[3];
    assign timer_one_count_input_out = r.gated[4];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in || tim.core_rst);

    ale_rate_a: assert property (
        ale_out && !double_speed_mode_in && !ale_off_in && r.kind == EMB_CYC_FETCH
        && !tim.half && $stable(double_speed_mode_in) |-> ##6 ale_out)
        else $error("address strobe not six clocks apart");
    ale_gap_a: assert property (data_half |-> !ale_out)
        else $error("address strobe during data access");
    ale_off_a: assert property (ale_off_in && external_fetch_select_in |-> !ale_out)
        else $error("address strobe while disabled");
    program_fetch_strobe_twice_a: assert property (
        r.kind == EMB_CYC_FETCH && tim.sub == 3'h0 |-> ##2 !program_fetch_strobe_n_out)
        else $error("fetch strobe missing in external fetch");
    program_fetch_strobe_skip_a: assert property (
        (r.kind == EMB_CYC_RD || r.kind == EMB_CYC_WR) |-> program_fetch_strobe_n_out)
        else $error("fetch strobe during data access");
    program_fetch_strobe_int_a: assert property (r.kind == EMB_CYC_INT |-> program_fetch_strobe_n_out)
        else $error("fetch strobe on internal fetch");
    fetch_int_a: assert property (
        tim.mc_end && !movx_req_in && external_fetch_select_in && pc_in < EMB_INT_LIMIT
        |=> r.kind == EMB_CYC_INT)
        else $error("low address not fetched internally");
    fetch_ext_a: assert property (
        tim.mc_end && !movx_req_in && !external_fetch_select_in |=> r.kind == EMB_CYC_FETCH)
        else $error("external select low yet internal fetch");
    addr_hold_a: assert property (
        $fell(ale_out) && r.kind != EMB_CYC_INT |-> port0_oe_out == 8'hFF
        && port0_out == $past(port0_out))
        else $error("low address moved at strobe fall");
    high_addr_a: assert property (r.kind == EMB_CYC_FETCH |-> port2_oe_out == 8'hFF)
        else $error("high address not driven on fetch");
    rd_latch_a: assert property (!p3_latch_in[EMB_P3_RD] |-> !third_port_pins_out[EMB_P3_RD])
        else $error("read strobe works with latch zero");

    fetch_c: cover property (r.kind == EMB_CYC_FETCH ##1 fetch_valid_out);
    read_c: cover property (rd_act ##[1:8] read_valid_out);
    write_c: cover property (wr_act && port0_oe_out == 8'hFF);
    x2_c: cover property (double_speed_mode_in && ale_out ##3 ale_out);
endmodule : emb_ext_bus

/* File: emb_pkg.sv */
// Purpose: shared constants and types for the external memory bus strobe block
// Assumes: clk_in is the oscillator itself, 50 MHz, one machine cycle is 12 or 6 clocks
// Notes: a machine cycle is two halves, each half opens with one address slot except the second half of a data access
//
// Operation
// - reset only after two machine cycles high
// - address strobe at osc/6, osc/3 double-speed
// - no address strobe in the second half of data access cycles
// - software may stop address strobe, internal execution
// - fetch strobe twice per external fetch cycle
// - data access skips both fetch strobes
// - fetch strobe idle for internal fetches
// - select high: internal below 8000H, else external
// - select low: every fetch is external
// - third port functions need latch one, except two
// - third port bit order of secondary functions
// - synchronous serial: receive pin bidirectional, transmit clocks
// - latch one: pin pulled high, readable
// - low address and data multiplexed on port 0
// - high address on port 2 when wide
////////////////////////////////////////////////////////////////////////////////
package emb_pkg;
    // clocks per half machine cycle, each half carries one address strobe except the second half of a data access
    localparam logic [2:0] EMB_HALF_STD = 3'h6;
    localparam logic [2:0] EMB_HALF_X2 = 3'h3;
    // sub-phases 0 and 1 carry the address, strobes follow
    localparam logic [2:0] EMB_ADDR_SUBS = 3'h2;
    // reset pin must stay high this many half cycles (two machine cycles)
    localparam logic [4:0] EMB_RST_HALVES = 5'h04;
    // first program address served by external memory when select is high
    localparam logic [15:0] EMB_INT_LIMIT = 16'h8000;
    // third port bit positions of the secondary functions
    localparam int EMB_P3_RXD = 0;
    localparam int EMB_P3_TXD = 1;
    localparam int EMB_P3_IRQ0 = 2;
    localparam int EMB_P3_IRQ1 = 3;
    localparam int EMB_P3_T0 = 4;
    localparam int EMB_P3_T1 = 5;
    localparam int EMB_P3_WR = 6;
    localparam int EMB_P3_RD = 7;
    // functions that work whatever the latch holds
    localparam logic [7:0] EMB_P3_EXEMPT = 8'h42;
    // functions driven push-pull rather than quasi-bidirectional
    localparam logic [7:0] EMB_P3_STRONG = 8'hC0;

    typedef enum logic [1:0] {
        EMB_CYC_INT,
        EMB_CYC_FETCH,
        EMB_CYC_RD,
        EMB_CYC_WR
    } emb_cyc_t;
endpackage : emb_pkg

/* File: emb_tim_if.sv */
// Purpose: machine cycle timing carried from the timing generator to the bus logic
// Assumes: all signals belong to clk_in
// Notes: sub and half come straight from flip-flops
////////////////////////////////////////////////////////////////////////////////
interface emb_tim_if;
    logic x2;        // double-speed mode
    logic core_rst;  // filtered device reset
    logic half;      // which half of the machine cycle
    logic mc_end;    // last clock of a machine cycle
    logic [2:0] sub; // clock within the half
    logic [2:0] hl;  // clocks per half

    modport gen (input x2, output core_rst, half, mc_end, sub, hl);
    modport use_p (output x2, input core_rst, half, mc_end, sub, hl);
endinterface : emb_tim_if

/* File: emb_timing.sv */
// Purpose: machine cycle phase counter and reset pin filter
// Assumes: reset pin is synchronous to clk_in
// Notes: a switch to double speed past sub-phase 2 wraps the half at once
////////////////////////////////////////////////////////////////////////////////
module emb_timing (
    input wire logic clk_in,       // oscillator clock
    input wire logic sys_rst_in,   // synchronous reset, active high
    input wire logic reset_pin_in, // device reset pin level
    emb_tim_if.gen tim             // timing to the bus logic
);
    import emb_pkg::*;

    typedef struct packed {
        logic [2:0] sub;
        logic half;
        logic [4:0] rcnt;
        logic core_rst;
    } emb_tim_st_t;

    emb_tim_st_t r;
    emb_tim_st_t n;
    logic [2:0] hl;
    logic [4:0] thr;

    assign hl = tim.x2 ? EMB_HALF_X2 : EMB_HALF_STD;
    // threshold in clocks follows the current machine cycle length
    assign thr = 5'(hl) * EMB_RST_HALVES;

    ////////////////////////////////////////////////////////////////////////////
    // phase walk and reset filter
    always_comb begin
        n = r;
        if (r.sub >= hl - 3'h1) begin
            n.sub = 3'h0;
            n.half = !r.half;
        end else begin
            n.sub = r.sub + 3'h1;
        end
        // a low pin clears the count, short pulses never reach threshold
        if (!reset_pin_in) begin
            n.rcnt = 5'h00;
        end else if (r.rcnt < thr) begin
            n.rcnt = r.rcnt + 5'h01;
        end
        n.core_rst = reset_pin_in && (n.rcnt >= thr);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r <= '{sub: 3'h0, half: 1'b0, rcnt: 5'h00, core_rst: 1'b1};
        end else begin
            r <= n;
        end
    end

    assign tim.sub = r.sub;
    assign tim.half = r.half;
    assign tim.hl = hl;
    assign tim.core_rst = r.core_rst;
    assign tim.mc_end = r.half && (r.sub >= hl - 3'h1);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    short_pulse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !reset_pin_in |=> !tim.core_rst)
        else $error("reset taken without pin held high");
    long_pulse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (reset_pin_in && !tim.x2) [*8] ##1 (reset_pin_in && !tim.x2) [*8]
        ##1 (reset_pin_in && !tim.x2) [*8] |=> tim.core_rst)
        else $error("reset not taken after two machine cycles");
endmodule : emb_timing

/* File: emb_mem_model.sv */
// Purpose: external code and data memory with address latch beside the bus block
// Assumes: strobes are active low and move on clk_in
// Notes: an undriven port 0 shows the inverse of its last level
////////////////////////////////////////
module emb_mem_model (
    input wire logic clk_in,         // oscillator clock
    input wire logic ale_in,         // address latch strobe
    input wire logic [7:0] p0_in,    // port 0 drive value
    input wire logic [7:0] p0_oe_in, // port 0 drive enable
    input wire logic [7:0] p2_in,    // high address byte
    input wire logic fetch_n_in,     // program fetch strobe
    input wire logic rd_n_in,        // data read strobe
    input wire logic wr_n_in,        // data write strobe
    output logic [7:0] pin_out       // resolved port 0 level
);
    logic [7:0] lat_r;
    logic [7:0] last_r = 8'h00;
    logic [7:0] mem [0:65535];
    logic [15:0] a;
    logic drv;
    // contents follow the address so any byte is predictable
    initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
    // low byte taken as the strobe falls
    always @(negedge ale_in) lat_r <= p0_in;
    assign a = {p2_in, lat_r};
    // memory drives only while a strobe asks
    assign drv = ~fetch_n_in | ~rd_n_in;
    assign pin_out = (p0_oe_in & p0_in) | (~p0_oe_in & (drv ? mem[a] : ~last_r));
    // memory written at every rising clock edge while the write strobe is low
    always @(posedge clk_in) begin
        last_r <= pin_out;
        if (wr_n_in === 1'b0) mem[a] <= p0_in;
    end
endmodule : emb_mem_model

/* File: emb_ext_bus_bench.sv */
// Purpose: self-checking bench for the external bus strobe block
// Assumes: requests change at the falling edge inside the mc_end clock
// Notes: fetch and read bytes are checked in order through one queue
////////////////////////////////////////
module emb_ext_bus_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import emb_pkg::*;
    logic clk_in = 0, sys_rst_in = 1, reset_pin_in = 0, double_speed_mode_in = 0, ale_off_in = 0;
    logic external_fetch_select_in = 0, movx_req_in = 0, movx_wr_in = 0, movx_wide_in = 1;
    logic serial_tx_en_in = 0, serial_tx_in = 0, serial_sync_in = 0, serial_rx_drive_in = 0;
    logic serial_rx_val_in = 0, ale_out, program_fetch_strobe_n_out, core_rst_out, mc_end_out;
    logic fetch_valid_out, read_valid_out, serial_rx_data_out, external_irq_zero_n_out;
    logic external_irq_one_n_out, timer_zero_count_input_out, timer_one_count_input_out;
    logic [15:0] pc_in = 16'h0000, movx_addr_in = 16'h0000, wr_a = 16'h0000;
    logic [7:0] movx_wdata_in = 8'h00, p0_latch_in = 8'hFF, p2_latch_in = 8'hFF, wr_d;
    logic [7:0] p3_latch_in = 8'hFF, ext_p3 = 8'hFF, port0_in, port0_out, port0_oe_out;
    logic [7:0] port2_out, port2_oe_out, third_port_pins_in, third_port_pins_out;
    logic [7:0] third_port_pins_oe_out, fetch_byte_out, read_data_out, third_port_read_out;
    logic [1:0] p4_latch_in = 2'h3, fourth_port_pins_out, fourth_port_pins_oe_out;
    logic [31:0] r;
    logic [7:0] exp_q [$];
    int err_count = 0, checks = 0, seed = 8416, n_ale = 0, n_ps = 0, gap = 0, run = 0, cyc = 0;
    emb_ext_bus emb_ext_bus_i (.clk_in, .sys_rst_in, .reset_pin_in, .double_speed_mode_in,
        .external_fetch_select_in, .ale_off_in, .pc_in, .movx_req_in, .movx_wr_in,
        .movx_wide_in, .movx_addr_in, .movx_wdata_in, .p0_latch_in, .p2_latch_in, .p3_latch_in,
        .p4_latch_in, .serial_tx_en_in, .serial_tx_in, .serial_sync_in, .serial_rx_drive_in,
        .serial_rx_val_in, .port0_in, .port0_out, .port0_oe_out, .port2_out, .port2_oe_out,
        .third_port_pins_in, .third_port_pins_out, .third_port_pins_oe_out,
        .fourth_port_pins_out, .fourth_port_pins_oe_out, .ale_out, .program_fetch_strobe_n_out,
        .core_rst_out, .mc_end_out, .fetch_byte_out, .fetch_valid_out, .read_data_out,
        .read_valid_out, .third_port_read_out, .serial_rx_data_out, .external_irq_zero_n_out,
        .external_irq_one_n_out, .timer_zero_count_input_out, .timer_one_count_input_out);
    emb_mem_model emb_mem_model_i (.clk_in, .ale_in(ale_out), .p0_in(port0_out),
        .p0_oe_in(port0_oe_out), .p2_in(port2_out), .fetch_n_in(program_fetch_strobe_n_out),
        .rd_n_in(~(third_port_pins_oe_out[7] & ~third_port_pins_out[7])),
        .wr_n_in(~(third_port_pins_oe_out[6] & ~third_port_pins_out[6])), .pin_out(port0_in));
    // undriven third port pins show the outside level
    assign third_port_pins_in = (third_port_pins_oe_out & third_port_pins_out)
        | (~third_port_pins_oe_out & ext_p3);
    initial forever #10 clk_in = ~clk_in;
    ////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task close_out;
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    function logic [7:0] pop;
        return exp_q.size() ? exp_q.pop_front() : 8'hXX;
    endfunction : pop
    function logic [7:0] code_of(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : code_of
    // bounded wait for the clock in which a request is taken
    task wait_end;
        int k;
        k = 0;
        @(negedge clk_in);
        while ((mc_end_out !== 1'b1 || core_rst_out !== 1'b0) && k < 100) begin
            @(negedge clk_in);
            k++;
        end
        if (k == 100) err_count++;
    endtask : wait_end
    // place one request and note the bytes it must return
    task req(input logic sel, rq, wr, input logic [15:0] a, input logic [7:0] wd);
        external_fetch_select_in = sel;
        pc_in = a;
        movx_addr_in = a;
        movx_req_in = rq;
        movx_wr_in = wr;
        movx_wdata_in = wd;
        n_ale = 0;
        n_ps = 0;
        if (rq && wr) {wr_a, wr_d} = {a, wd};
        if (rq && !wr) exp_q.push_back(a == wr_a ? wr_d : code_of(a));
        if (!rq && (!sel || a >= EMB_INT_LIMIT)) exp_q.push_back(code_of(a));
        if (!rq && (!sel || a >= EMB_INT_LIMIT)) exp_q.push_back(code_of(a + 16'h0001));
    endtask : req
    ////////////////////////////////////////
    // strobe counts, strobe spacing and cycle ceiling
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        run <= ale_out ? 1 : run + 1;
        if (ale_out === 1'b1) n_ale <= n_ale + 1;
        if (ale_out === 1'b1) gap <= run;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end
    // fetch strobe falls counted just after they happen, zero-width glitches drop out
    always @(negedge program_fetch_strobe_n_out) #1 if (program_fetch_strobe_n_out === 1'b0) n_ps++;
    // returned bytes against the oldest note
    always @(negedge clk_in) begin
        if (fetch_valid_out === 1'b1) chk(fetch_byte_out, pop());
        if (read_valid_out === 1'b1) chk(read_data_out, pop());
    end
    ////////////////////////////////////////
    initial begin
        r = $random(seed);
        p4_latch_in = r[1:0];
        repeat (8) @(negedge clk_in);
        sys_rst_in = 0;
        chk({fourth_port_pins_oe_out, fourth_port_pins_out}, {4'h0, ~p4_latch_in, p4_latch_in});
        for (int i = 0; i < 3; i++) begin
            wait_end();
            req(0, 0, 0, i == 0 ? 16'h1234 : (i == 1 ? 16'h00FF : 16'hFFFE), 8'h00);
        end
        wait_end();
        chk(n_ale, 2);
        chk(n_ps, 2);
        chk(gap, 6);
        double_speed_mode_in = 1;
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            req(0, 0, 0, r[15:0], 8'h00);
            wait_end();
        end
        chk(gap, 3);
        chk(n_ps, 2);
        req(1, 0, 0, 16'h7FFF, 8'h00);
        wait_end();
        chk(n_ps, 0);
        ale_off_in = 1;
        req(1, 0, 0, 16'h0100, 8'h00);
        wait_end();
        chk(n_ale, 0);
        ale_off_in = 0;
        req(1, 0, 0, EMB_INT_LIMIT, 8'h00);
        wait_end();
        chk(n_ps, 2);
        r = $random(seed);
        req(0, 1, 1, 16'h0120, r[7:0]);
        // leave double speed only once the request is taken, else the cycle end moves
        @(negedge clk_in);
        double_speed_mode_in = 0;
        wait_end();
        req(0, 1, 0, 16'h0120, 8'h00);
        wait_end();
        chk(n_ale, 1);
        chk(n_ps, 0);
        req(1, 0, 0, 16'h0000, 8'h00);
        // gated inputs idle while the latch holds zero
        p3_latch_in = 8'h00;
        ext_p3 = r[15:8] & 8'hC3;
        repeat (4) @(negedge clk_in);
        chk({external_irq_one_n_out, external_irq_zero_n_out, serial_rx_data_out}, 8'h07);
        chk({timer_one_count_input_out, timer_zero_count_input_out}, 8'h00);
        p3_latch_in = 8'hFF;
        ext_p3 = r[23:16];
        repeat (4) @(negedge clk_in);
        chk({external_irq_one_n_out, external_irq_zero_n_out}, ext_p3[3:2]);
        chk({timer_one_count_input_out, timer_zero_count_input_out}, ext_p3[5:4]);
        chk(serial_rx_data_out, ext_p3[0]);
        chk(third_port_read_out, ext_p3);
        // synchronous serial: receive pin carries data, transmit pin the shift clock
        {serial_sync_in, serial_rx_drive_in, serial_tx_en_in} = 3'h7;
        {serial_tx_in, serial_rx_val_in} = r[25:24];
        @(negedge clk_in);
        chk(third_port_pins_out[1:0], r[25:24]);
        // a 23-clock pulse must not reset, the 24th clock does
        reset_pin_in = 1;
        repeat (23) @(negedge clk_in);
        chk(core_rst_out, 1'b0);
        @(negedge clk_in);
        chk(core_rst_out, 1'b1);
        reset_pin_in = 0;
        repeat (4) @(negedge clk_in);
        chk(core_rst_out, 1'b0);
        chk(exp_q.size(), 8'h00);
        close_out();
    end
endmodule : emb_ext_bus_bench
